// ### ippl_pkg.sv
package ippl_pkg;

	localparam int unsigned IPPL_WIDTH = 6;

	// Register byte offsets
	localparam logic [7:0] IPPL_POLARITY_OFS = 8'h00;
	localparam logic [7:0] IPPL_DIR_OFS      = 8'h04;
	localparam logic [7:0] IPPL_OUT_OFS      = 8'h08;
	localparam logic [7:0] IPPL_MOMO_OFS     = 8'h0c;
	localparam logic [7:0] IPPL_IN_OFS       = 8'h10;
	localparam logic [7:0] IPPL_TRIG_OFS     = 8'h14;
	localparam logic [7:0] IPPL_PINS_OFS     = 8'h18;

	// Must-on field sits above must-off field in the set/clear register
	localparam int unsigned IPPL_MOMO_ON_POS  = 8;
	localparam int unsigned IPPL_MOMO_OFF_POS = 0;

	// Reset values
	localparam logic [5:0] IPPL_POLARITY_RST = 6'h3f;
	localparam logic [5:0] IPPL_DIR_RST      = 6'h00;
	localparam logic [5:0] IPPL_OUT_RST      = 6'h00;

	typedef struct packed {
		logic [5:0] polarity;
		logic [5:0] dir;
		logic [5:0] out_logic;
		logic [5:0] pin_out;
		logic [5:0] io_s1;
		logic [5:0] io_s2;
		logic [5:0] trig_s1;
		logic [5:0] trig_s2;
		logic [5:0] trig_prev;
		logic [5:0] trig_latch;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ippl_state_t;

endpackage

// ### ippl_io_port.sv
`timescale 1ns/1ps

// How it works
// - Polarity bit set selects active low or open; reset sets all six.
// - Port line n and trigger line n both use polarity bit n.
// - Active-low line reads asserted when pin is low.
// - Active-high line reads asserted when pin is high.
// - Active-open opto line asserted when no current flows (input low).
// - Active-closed opto line asserted when current flows (input high).
// - Software reads and writes logical values, except the raw pin levels read at PINS; polarity mapping sits between.
// - Trigger-port transitions to active level set a latch held until read.
// - A latched bit reads asserted even after the line went inactive.
// - A line already active when latching begins is latched too.
// - Output writes to lines configured as input are ignored.
module ippl_io_port
	import ippl_pkg::*;
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// General-purpose port pins; opto inputs read high while current flows
	input  wire logic [5:0]  io_pin_in,
	output logic      [5:0]  io_pin_out,
	output logic      [5:0]  io_pin_oe,
	// Trigger-bus lines, input only
	input  wire logic [5:0]  trig_pin_in
);

	ippl_state_t st_reg;
	ippl_state_t st_next;

	// Pin level to logical value: inverted where the polarity bit is set
	function automatic logic [5:0] to_logic(input logic [5:0] lvl, input logic [5:0] pol);
		to_logic = lvl ^ pol;
	endfunction

	// Refused access: unknown offset, or a write to a read-only one
	function automatic logic bad_access(input logic [7:0] a, input logic wr);
		case (a)
			IPPL_POLARITY_OFS, IPPL_DIR_OFS, IPPL_OUT_OFS, IPPL_MOMO_OFS: bad_access = 1'b0;
			IPPL_IN_OFS, IPPL_TRIG_OFS, IPPL_PINS_OFS:                    bad_access = wr;
			default:                                                       bad_access = 1'b1;
		endcase
	endfunction

	logic [5:0] io_logic;
	logic [5:0] trig_logic;
	logic       wr_acc;
	logic       rd_acc;

	assign io_logic   = to_logic(st_reg.io_s2, st_reg.polarity);
	assign trig_logic = to_logic(st_reg.trig_s2, st_reg.polarity);
	assign wr_acc     = psel && penable && pwrite;
	assign rd_acc     = psel && penable && !pwrite;

	always_comb begin
		st_next = st_reg;
		st_next.io_s1   = io_pin_in;
		st_next.io_s2   = st_reg.io_s1;
		st_next.trig_s1 = trig_pin_in;
		st_next.trig_s2 = st_reg.trig_s1;
		st_next.trig_prev = trig_logic;
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;
		st_next.prdata  = 32'h0000_0000;
		// Latch every active logical level, so rising edges and a line already active are both caught
		st_next.trig_latch = st_reg.trig_latch | trig_logic;
		// Answer is prepared in the setup cycle so data and error stand with pready
		if (psel && !penable) begin
			st_next.pready  = 1'b1;
			st_next.pslverr = bad_access(paddr, pwrite);
			if (!pwrite) begin
				case (paddr)
					IPPL_POLARITY_OFS: st_next.prdata = {26'h0, st_reg.polarity};
					IPPL_DIR_OFS:      st_next.prdata = {26'h0, st_reg.dir};
					IPPL_OUT_OFS:      st_next.prdata = {26'h0, st_reg.out_logic};
					IPPL_MOMO_OFS:     st_next.prdata = 32'h0000_0000;
					IPPL_IN_OFS:       st_next.prdata = {26'h0, io_logic};
					IPPL_TRIG_OFS:     st_next.prdata = {26'h0, st_next.trig_latch};
					IPPL_PINS_OFS:     st_next.prdata = {26'h0, st_reg.io_s2};
					default:           st_next.prdata = 32'h0000_0000;
				endcase
			end
		end
		if (wr_acc && st_reg.pready) begin
			case (paddr)
				IPPL_POLARITY_OFS: st_next.polarity = pwdata[5:0];
				IPPL_DIR_OFS:      st_next.dir = pwdata[5:0];
				IPPL_OUT_OFS: begin
					st_next.out_logic = (st_reg.out_logic & ~st_reg.dir)
						| (pwdata[5:0] & st_reg.dir);
				end
				IPPL_MOMO_OFS: begin
					// Must-on wins when both bits are set
					st_next.out_logic = ((st_reg.out_logic
						& ~pwdata[IPPL_MOMO_OFF_POS +: 6])
						| pwdata[IPPL_MOMO_ON_POS +: 6])
						& st_reg.dir | (st_reg.out_logic & ~st_reg.dir);
				end
				// Read-only and unmapped offsets change nothing
				default: st_next.dir = st_reg.dir;
			endcase
		end
		// Reload at the access edge so a pulse during the access is kept
		if (rd_acc && st_reg.pready && (paddr == IPPL_TRIG_OFS)) begin
			st_next.trig_latch = trig_logic;
		end
		// Logical output to pin level through the line's own polarity
		st_next.pin_out = to_logic(st_next.out_logic, st_next.polarity);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.polarity  <= IPPL_POLARITY_RST;
			st_reg.dir       <= IPPL_DIR_RST;
			st_reg.out_logic <= IPPL_OUT_RST;
			st_reg.pin_out   <= IPPL_POLARITY_RST ^ IPPL_OUT_RST;
			// Trigger syncs start at the idle level so no false latch follows reset
			st_reg.trig_s1   <= IPPL_POLARITY_RST;
			st_reg.trig_s2   <= IPPL_POLARITY_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	logic [5:0] oe_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_reg <= 6'h00;
		end else begin
			oe_reg <= st_next.dir;
		end
	end

	assign prdata     = st_reg.prdata;
	assign pready     = st_reg.pready;
	assign pslverr    = st_reg.pslverr;
	assign io_pin_out = st_reg.pin_out;
	assign io_pin_oe  = oe_reg;

	property p_trig_hold;
		@(posedge pclk) disable iff (!presetn)
		(st_reg.trig_latch != 6'h00) && !(rd_acc && pready && paddr == IPPL_TRIG_OFS)
		|=> ((st_reg.trig_latch & $past(st_reg.trig_latch)) == $past(st_reg.trig_latch));
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("Trigger latch dropped before read");

	property p_trig_catch;
		@(posedge pclk) disable iff (!presetn)
		(trig_logic != 6'h00) |=> ((st_reg.trig_latch & $past(trig_logic)) == $past(trig_logic));
	endproperty
	a_trig_catch: assert property (p_trig_catch) else $error("Active trigger line not latched");

	property p_trig_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && pready && paddr == IPPL_TRIG_OFS)
		|-> (prdata[5:0] == st_reg.trig_latch) ##1 (st_reg.trig_latch == $past(trig_logic));
	endproperty
	a_trig_read: assert property (p_trig_read) else $error("Trigger read did not reload latches");

	property p_in_ignored;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && pready) |=> ((st_reg.out_logic & ~$past(st_reg.dir))
			== ($past(st_reg.out_logic) & ~$past(st_reg.dir)));
	endproperty
	a_in_ignored: assert property (p_in_ignored) else $error("Write changed an input line");

	property p_pin_map;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |-> (io_pin_out == (st_reg.out_logic ^ st_reg.polarity));
	endproperty
	a_pin_map: assert property (p_pin_map) else $error("Pin level disagrees with polarity");

	property p_in_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && pready && paddr == IPPL_IN_OFS)
		|-> (prdata[5:0] == ($past(st_reg.io_s2) ^ $past(st_reg.polarity)));
	endproperty
	a_in_read: assert property (p_in_read) else $error("Logical input read wrong");

	property p_pol_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && pready && paddr == IPPL_POLARITY_OFS)
		|=> (st_reg.polarity == $past(pwdata[5:0]));
	endproperty
	a_pol_write: assert property (p_pol_write) else $error("Polarity write not taken");

	property p_pol_stable;
		@(posedge pclk) disable iff (!presetn)
		!(wr_acc && pready && paddr == IPPL_POLARITY_OFS) |=> $stable(st_reg.polarity);
	endproperty
	a_pol_stable: assert property (p_pol_stable) else $error("Polarity changed without write");

	// Bus phases shared by the checks below
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_rd(logic [7:0] a);
		rd_acc && pready && (paddr == a);
	endsequence

	sequence s_wr(logic [7:0] a);
		wr_acc && pready && (paddr == a);
	endsequence

	property p_rdy_setup;
		@(posedge pclk) disable iff (!presetn)
		s_setup
		|=> pready;
	endproperty
	a_rdy_setup: assert property (p_rdy_setup) else $error("No ready after setup");

	property p_rdy_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready
		|=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("Ready held too long");

	property p_rdy_cause;
		@(posedge pclk) disable iff (!presetn)
		pready
		|-> $past(psel && !penable);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("Ready without setup");

	property p_err_decode;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && bad_access(paddr, pwrite))
		|=> pslverr;
	endproperty
	a_err_decode: assert property (p_err_decode) else $error("Refused access not flagged");

	property p_err_rdy;
		@(posedge pclk) disable iff (!presetn)
		pslverr
		|-> pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("Error outside ready");

	property p_rdata_idle;
		@(posedge pclk) disable iff (!presetn)
		!pready
		|-> (prdata == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside ready");

	property p_rdata_high;
		@(posedge pclk) disable iff (!presetn)
		pready
		|-> (prdata[31:6] == 26'h0);
	endproperty
	a_rdata_high: assert property (p_rdata_high) else $error("Upper read bits not zero");

	property p_dir_write;
		@(posedge pclk) disable iff (!presetn)
		s_wr(IPPL_DIR_OFS)
		|=> (st_reg.dir == $past(pwdata[5:0]));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("Direction write not taken");

	property p_oe_dir;
		@(posedge pclk) disable iff (!presetn)
		1'b1
		|-> (io_pin_oe == st_reg.dir);
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("Output enable disagrees with direction");

	property p_out_write;
		@(posedge pclk) disable iff (!presetn)
		s_wr(IPPL_OUT_OFS)
		|=> ((st_reg.out_logic & $past(st_reg.dir)) == ($past(pwdata[5:0]) & $past(st_reg.dir)));
	endproperty
	a_out_write: assert property (p_out_write) else $error("Output write not taken");

	property p_momo_on;
		@(posedge pclk) disable iff (!presetn)
		s_wr(IPPL_MOMO_OFS)
		|=> ((st_reg.out_logic & $past(pwdata[IPPL_MOMO_ON_POS +: 6] & st_reg.dir))
			== $past(pwdata[IPPL_MOMO_ON_POS +: 6] & st_reg.dir));
	endproperty
	a_momo_on: assert property (p_momo_on) else $error("Must-on bit not set");

	property p_momo_off;
		@(posedge pclk) disable iff (!presetn)
		s_wr(IPPL_MOMO_OFS)
		|=> ((st_reg.out_logic & $past(pwdata[IPPL_MOMO_OFF_POS +: 6]
			& ~pwdata[IPPL_MOMO_ON_POS +: 6] & st_reg.dir)) == 6'h00);
	endproperty
	a_momo_off: assert property (p_momo_off) else $error("Must-off bit not cleared");

	property p_ro_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc && pready && ((paddr == IPPL_IN_OFS) || (paddr == IPPL_TRIG_OFS)
			|| (paddr == IPPL_PINS_OFS)))
		|-> pslverr ##1 ($stable(st_reg.out_logic) && $stable(st_reg.dir));
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("Read-only write took effect");

	property p_trig_edge;
		@(posedge pclk) disable iff (!presetn)
		((trig_logic & ~st_reg.trig_prev) != 6'h00)
		|=> ((st_reg.trig_latch & $past(trig_logic & ~st_reg.trig_prev))
			== $past(trig_logic & ~st_reg.trig_prev));
	endproperty
	a_trig_edge: assert property (p_trig_edge) else $error("Active-going edge not latched");

	property p_trig_quiet;
		@(posedge pclk) disable iff (!presetn)
		((trig_logic == 6'h00) && (st_reg.trig_latch == 6'h00))
		|=> (st_reg.trig_latch == 6'h00);
	endproperty
	a_trig_quiet: assert property (p_trig_quiet) else $error("Latch set with no activity");

	property p_pins_read;
		@(posedge pclk) disable iff (!presetn)
		s_rd(IPPL_PINS_OFS)
		|-> (prdata[5:0] == $past(st_reg.io_s2));
	endproperty
	a_pins_read: assert property (p_pins_read) else $error("Pin level read wrong");

	property p_pol_read;
		@(posedge pclk) disable iff (!presetn)
		s_rd(IPPL_POLARITY_OFS)
		|-> (prdata[5:0] == $past(st_reg.polarity));
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("Polarity read wrong");

	property p_pin_stable;
		@(posedge pclk) disable iff (!presetn)
		!(wr_acc && pready && ((paddr == IPPL_OUT_OFS) || (paddr == IPPL_MOMO_OFS)
			|| (paddr == IPPL_POLARITY_OFS)))
		|=> $stable(io_pin_out);
	endproperty
	a_pin_stable: assert property (p_pin_stable) else $error("Pin drive moved without write");

endmodule

// ### ippl_field_model.sv
`timescale 1ns/1ps
module ippl_field_model
	import ippl_pkg::*;
(
	// Field wiring and opto levels, 1 = high or current flowing
	input  wire logic [5:0] field_lvl,
	// Port pins
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	output logic      [5:0] pin_in
);
	// Driven lines read back their own drive, others follow the field
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & field_lvl);
endmodule

// ### tb_ippl_io_port.sv
`timescale 1ns/1ps
module tb_ippl_io_port
	import ippl_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [5:0]  io_pin_in, io_pin_out, io_pin_oe, trig_pin_in, field_lvl;
	logic        err;
	int          error_cnt = 0;
	int          comparisons = 0;

	ippl_io_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
		.io_pin_oe(io_pin_oe), .trig_pin_in(trig_pin_in));
	ippl_field_model field (.field_lvl(field_lvl), .pin_out(io_pin_out), .pin_oe(io_pin_oe),
		.pin_in(io_pin_in));

	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Holds the request until pready is sampled, then leaves one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		check(name, rdat, exp);
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		#20000;
		error_cnt++;
		end_sim();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		field_lvl = 6'h00;
		trig_pin_in = 6'h3f;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("pin_out", {26'h0, io_pin_out}, 32'h3f);
		rd(IPPL_POLARITY_OFS, 32'h3f, "polarity");
		rd(IPPL_IN_OFS, 32'h3f, "in_low");
		apb(1'b1, IPPL_POLARITY_OFS, 32'h05);
		rd(IPPL_IN_OFS, 32'h05, "in_mixed");
		field_lvl <= 6'h21;
		repeat (4) @(posedge pclk);
		rd(IPPL_IN_OFS, 32'h24, "in_opto");
		apb(1'b1, IPPL_DIR_OFS, 32'h0f);
		apb(1'b1, IPPL_OUT_OFS, 32'h3f);
		rd(IPPL_OUT_OFS, 32'h0f, "out_masked");
		check("pin_drive", {26'h0, io_pin_out & io_pin_oe}, 32'h0a);
		apb(1'b1, IPPL_MOMO_OFS, 32'h0203);
		rd(IPPL_OUT_OFS, 32'h0e, "out_momo");
		apb(1'b1, 8'h40, 32'h1);
		check("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, IPPL_POLARITY_OFS, 32'h3f);
		repeat (4) @(posedge pclk);
		apb(1'b0, IPPL_TRIG_OFS, 32'h0);
		rd(IPPL_TRIG_OFS, 32'h00, "trig_idle");
		trig_pin_in <= 6'h33;
		repeat (3) @(posedge pclk);
		trig_pin_in <= 6'h37;
		repeat (5) @(posedge pclk);
		rd(IPPL_TRIG_OFS, 32'h0c, "trig_pulse");
		rd(IPPL_TRIG_OFS, 32'h08, "trig_reload");
		end_sim();
	end
endmodule
